// >>> core/dual_timer_counter_control.sv
// Two 16-bit timer/counters with external request flags, AXI4-Lite slave.
// Assumes pins synchronous to i_clk_sys and one-cycle vector acknowledges.
//
// Functional notes
// [R1] Gate one set: timer one runs only while request pin one high and run.
// [R2] Gate zero set: timer zero needs pin zero high; clear: run bit alone.
// [R3] Mode bit 6 picks timer one source: count pin one or system clock.
// [R4] Mode bit 2 picks timer zero source: count pin zero or system clock.
// [R5] Mode 00: high byte counts, low five bits prescale ahead of it.
// [R6] Mode 01: high and low bytes form one 16-bit counter.
// [R7] Mode 10: low byte counts and reloads from high byte on overflow.
// [R8] Mode 11 on timer one stops timer one.
// [R9] Mode 11 on timer zero: low byte is an independent 8-bit counter.
// [R10] Timer zero mode 11: high byte times clocks under timer one controls.
// [R11] Control bit 7 set on timer one overflow, cleared on vectoring.
// [R12] Control bit 5 set on timer zero overflow, cleared on vectoring.
// [R13] Control bit 6 starts and stops timer one.
// [R14] Control bit 4 starts and stops timer zero.
// [R15] Control bit 3: request one flag, set by falling edge or low level.
// [R16] Control bit 2: trigger type one, 1 edge, 0 low level.
// [R17] Control bit 1: request zero flag, set by edge or level per bit 0.
// [R18] Control bit 0: trigger type zero, 1 edge, 0 low level.
// [R19] Edge flag cleared on vectoring; level flag follows the pin.
// [R20] Timer function increments once per core clock.
// [R21] Counter function counts a high sample followed by a low sample.
// [R22] Count pin drivers hold each level at least one clock.
`timescale 1ns/1ps
`include "tc_map.svh"
module dual_timer_counter_control import tc_pkg::*; (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // AXI4-Lite write
  input wire logic [`TC_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read
  input wire logic [`TC_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Pins
  input wire logic i_count_pin_zero,
  input wire logic i_count_pin_one,
  input wire logic i_ext_request_pin_zero,
  input wire logic i_ext_request_pin_one,
  // Vector acknowledges from the interrupt logic
  input wire logic i_vec_ack_overflow_zero,
  input wire logic i_vec_ack_overflow_one,
  input wire logic i_vec_ack_ext_zero,
  input wire logic i_vec_ack_ext_one,
  // Request flags
  output logic o_overflow_flag_zero,
  output logic o_overflow_flag_one,
  output logic o_ext_request_flag_zero,
  output logic o_ext_request_flag_one
);
  // ********************************************************
  // Count step
  // ********************************************************
  // Returns {overflow, high, low} after one count in the given mode
  function automatic logic [16:0] step(input timer_mode_t m, input byte_t th,
                                       input byte_t tl);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    s13 = {1'b0, th, tl[4:0]} + 14'h0001;
    s16 = {1'b0, th, tl} + 17'h0_0001;
    s8 = {1'b0, tl} + 9'h001;
    unique case (m)
      MODE_PRESCALE: step = {s13[13], s13[12:5], tl[7:5], s13[4:0]}; // [R5]
      MODE_CASCADE: step = s16; // [R6]
      MODE_RELOAD: step = {s8[8], th, s8[8] ? th : s8[7:0]}; // [R7]
      MODE_SPLIT: step = {s8[8], th, s8[7:0]}; // [R9]
    endcase
  endfunction

  // ********************************************************
  // Registers
  // ********************************************************
  byte_t mode_cfg, th_zero, tl_zero, th_one, tl_one;
  logic run_bit_zero, run_bit_one, trigger_type_zero, trigger_type_one;
  timer_mode_t mode_zero, mode_one;
  logic tick_zero, tick_one, tick_th_split;
  logic [16:0] next_zero, next_one;
  logic set_ovf_zero, set_ovf_one;
  assign mode_zero = timer_mode_t'(mode_cfg[`TC_MOD_MODE_ZERO_HI:`TC_MOD_MODE_ZERO_LO]);
  assign mode_one = timer_mode_t'(mode_cfg[`TC_MOD_MODE_ONE_HI:`TC_MOD_MODE_ONE_LO]);

  // ********************************************************
  // Bus slave
  // ********************************************************
  logic [`TC_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data, rd_word;
  logic [3:0] wr_strb;
  logic do_wr, wr_ctl, wr_mod, wr_cnt_zero, wr_cnt_one, rd_hit;
  assign do_wr = !o_awready && !o_wready && !o_bvalid;
  assign wr_ctl = do_wr && wr_addr == `TC_OFS_CONTROL && wr_strb[0];
  assign wr_mod = do_wr && wr_addr == `TC_OFS_MODE && wr_strb[0];
  assign wr_cnt_zero = do_wr && wr_addr == `TC_OFS_COUNT_ZERO;
  assign wr_cnt_one = do_wr && wr_addr == `TC_OFS_COUNT_ONE;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `TC_RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (o_awready && i_awvalid) begin
        o_awready <= 1'b0;
        wr_addr <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        o_wready <= 1'b0;
        wr_data <= i_wdata;
        wr_strb <= i_wstrb;
      end
      if (do_wr) begin
        o_bvalid <= 1'b1;
        o_bresp <= (wr_addr == `TC_OFS_CONTROL || wr_addr == `TC_OFS_MODE ||
                    wr_addr == `TC_OFS_COUNT_ZERO || wr_addr == `TC_OFS_COUNT_ONE)
                   ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    unique case (i_araddr)
      `TC_OFS_CONTROL: rd_word = {24'h00_0000, o_overflow_flag_one, run_bit_one,
                                  o_overflow_flag_zero, run_bit_zero,
                                  o_ext_request_flag_one, trigger_type_one,
                                  o_ext_request_flag_zero, trigger_type_zero};
      `TC_OFS_MODE: rd_word = {24'h00_0000, mode_cfg};
      `TC_OFS_COUNT_ZERO: rd_word = {16'h0000, th_zero, tl_zero};
      `TC_OFS_COUNT_ONE: rd_word = {16'h0000, th_one, tl_one};
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `TC_RESP_OKAY;
    end else if (o_arready && i_arvalid) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_word;
      o_rresp <= rd_hit ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ********************************************************
  // Configuration and run bits
  // ********************************************************
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_cfg <= `TC_RST_MODE;
    end else if (wr_mod) begin
      mode_cfg <= wr_data[7:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_bit_zero <= 1'b0;
      run_bit_one <= 1'b0;
      trigger_type_zero <= 1'b0;
      trigger_type_one <= 1'b0;
    end else if (wr_ctl) begin
      run_bit_one <= wr_data[`TC_CTL_RUN_ONE]; // [R13]
      run_bit_zero <= wr_data[`TC_CTL_RUN_ZERO]; // [R14]
      trigger_type_one <= wr_data[`TC_CTL_TRIG_ONE]; // [R16]
      trigger_type_zero <= wr_data[`TC_CTL_TRIG_ZERO]; // [R18]
    end
  end

  // ********************************************************
  // Count enables
  // ********************************************************
  count_source u_src_zero (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_count_pin(i_count_pin_zero),
    .i_gate_pin(i_ext_request_pin_zero),
    .i_run(run_bit_zero),
    .i_gate_en(mode_cfg[`TC_MOD_GATE_ZERO]),
    .i_counter_sel(mode_cfg[`TC_MOD_CSEL_ZERO]),
    .o_tick(tick_zero)
  );
  count_source u_src_one (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_count_pin(i_count_pin_one),
    .i_gate_pin(i_ext_request_pin_one),
    .i_run(run_bit_one),
    .i_gate_en(mode_cfg[`TC_MOD_GATE_ONE]),
    .i_counter_sel(mode_cfg[`TC_MOD_CSEL_ONE]),
    .o_tick(tick_one)
  );
  // Split high byte counts clocks on the run bit of timer one alone
  assign tick_th_split = mode_zero == MODE_SPLIT && run_bit_one; // [R10]
  assign next_zero = step(mode_zero, th_zero, tl_zero);
  assign next_one = step(mode_one, th_one, tl_one);

  // ********************************************************
  // Counters
  // ********************************************************
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      th_zero <= `TC_RST_BYTE;
      tl_zero <= `TC_RST_BYTE;
    end else if (wr_cnt_zero) begin
      if (wr_strb[0]) tl_zero <= wr_data[7:0];
      if (wr_strb[1]) th_zero <= wr_data[15:8];
    end else begin
      if (tick_zero) begin
        tl_zero <= next_zero[7:0]; // [R5] [R6] [R7] [R9]
        if (mode_zero != MODE_SPLIT) th_zero <= next_zero[15:8];
      end
      if (tick_th_split) th_zero <= th_zero + 8'h01; // [R10]
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      th_one <= `TC_RST_BYTE;
      tl_one <= `TC_RST_BYTE;
    end else if (wr_cnt_one) begin
      if (wr_strb[0]) tl_one <= wr_data[7:0];
      if (wr_strb[1]) th_one <= wr_data[15:8];
    end else if (tick_one && mode_one != MODE_SPLIT) begin // [R8]
      {th_one, tl_one} <= next_one[15:0];
    end
  end

  // ********************************************************
  // Overflow flags
  // ********************************************************
  assign set_ovf_zero = tick_zero && next_zero[16] && !wr_cnt_zero;
  assign set_ovf_one = (mode_zero == MODE_SPLIT)
                       ? (tick_th_split && th_zero == `TC_BYTE_ALL_ONES && !wr_cnt_zero) // [R10]
                       : (tick_one && next_one[16] && mode_one != MODE_SPLIT && !wr_cnt_one);
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_overflow_flag_zero <= 1'b0;
    end else if (set_ovf_zero) begin
      o_overflow_flag_zero <= 1'b1; // [R12]
    end else if (wr_ctl) begin
      o_overflow_flag_zero <= wr_data[`TC_CTL_OVF_ZERO];
    end else if (i_vec_ack_overflow_zero) begin
      o_overflow_flag_zero <= 1'b0; // [R12]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_overflow_flag_one <= 1'b0;
    end else if (set_ovf_one) begin
      o_overflow_flag_one <= 1'b1; // [R11]
    end else if (wr_ctl) begin
      o_overflow_flag_one <= wr_data[`TC_CTL_OVF_ONE];
    end else if (i_vec_ack_overflow_one) begin
      o_overflow_flag_one <= 1'b0; // [R11]
    end
  end

  // ********************************************************
  // External request flags
  // ********************************************************
  ext_request_unit u_ext_zero (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_pin(i_ext_request_pin_zero),
    .i_trig_edge(trigger_type_zero),
    .i_vec_ack(i_vec_ack_ext_zero),
    .i_sw_we(wr_ctl),
    .i_sw_val(wr_data[`TC_CTL_EXT_ZERO]),
    .o_flag(o_ext_request_flag_zero)
  );
  ext_request_unit u_ext_one (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_pin(i_ext_request_pin_one),
    .i_trig_edge(trigger_type_one),
    .i_vec_ack(i_vec_ack_ext_one),
    .i_sw_we(wr_ctl),
    .i_sw_val(wr_data[`TC_CTL_EXT_ONE]),
    .o_flag(o_ext_request_flag_one)
  );
  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  property p_gate_one;
    mode_cfg[`TC_MOD_GATE_ONE] && !i_ext_request_pin_one && !wr_cnt_one
      |=> {th_one, tl_one} == $past({th_one, tl_one});
  endproperty
  a_gate_one: assert property (p_gate_one) else $error("timer one ran gated"); // [R1]
  property p_gate_zero;
    mode_cfg[`TC_MOD_GATE_ZERO] && !i_ext_request_pin_zero && !wr_cnt_zero
      && mode_zero != MODE_SPLIT |=> {th_zero, tl_zero} == $past({th_zero, tl_zero});
  endproperty
  a_gate_zero: assert property (p_gate_zero) else $error("timer zero ran gated"); // [R2]
  property p_timer_fn;
    run_bit_zero && !mode_cfg[`TC_MOD_GATE_ZERO] && !mode_cfg[`TC_MOD_CSEL_ZERO]
      && mode_zero == MODE_CASCADE && !wr_cnt_zero
      |=> {th_zero, tl_zero} == $past({th_zero, tl_zero}) + 16'h0001;
  endproperty
  a_timer_fn: assert property (p_timer_fn) else $error("no clock count"); // [R6]
  property p_counter_fn;
    mode_cfg[`TC_MOD_CSEL_ZERO] && !($past(i_count_pin_zero) && !i_count_pin_zero)
      && !wr_cnt_zero && mode_zero != MODE_SPLIT
      |=> {th_zero, tl_zero} == $past({th_zero, tl_zero});
  endproperty
  a_counter_fn: assert property (p_counter_fn) else $error("count without edge"); // [R4]
  property p_reload;
    mode_zero == MODE_RELOAD && tick_zero && tl_zero == `TC_BYTE_ALL_ONES && !wr_cnt_zero
      |=> tl_zero == $past(th_zero) && o_overflow_flag_zero;
  endproperty
  a_reload: assert property (p_reload) else $error("reload missed"); // [R7]
  property p_hold_one;
    mode_one == MODE_SPLIT && !wr_cnt_one |=> $stable({th_one, tl_one});
  endproperty
  a_hold_one: assert property (p_hold_one) else $error("timer one moved"); // [R8]
  property p_split_high;
    mode_zero == MODE_SPLIT && run_bit_one && !wr_cnt_zero
      |=> th_zero == $past(th_zero) + 8'h01;
  endproperty
  a_split_high: assert property (p_split_high) else $error("split high stuck"); // [R10]
  property p_ext_edge;
    trigger_type_zero && $past(i_ext_request_pin_zero) && !i_ext_request_pin_zero
      |=> o_ext_request_flag_zero;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("edge lost"); // [R17]
  property p_ext_level;
    !trigger_type_one |=> o_ext_request_flag_one == !$past(i_ext_request_pin_one);
  endproperty
  a_ext_level: assert property (p_ext_level) else $error("level not followed"); // [R19]
  c_reload: cover property (mode_zero == MODE_RELOAD && set_ovf_zero);
  c_split: cover property (mode_zero == MODE_SPLIT && set_ovf_one);
  c_ext_edge: cover property (trigger_type_one && o_ext_request_flag_one);
  c_write: cover property (o_bvalid && i_bready);
endmodule

// >>> shared/tc_map.svh
// Register offsets, field positions and reset values of the timer pair.
// Assumes byte addresses on a 32-bit register bus, one register per word.
`ifndef TC_MAP_SVH
`define TC_MAP_SVH

// ********************************************************
// Offsets
// ********************************************************
`define TC_ADDR_W 8
`define TC_OFS_CONTROL 8'h88
`define TC_OFS_MODE 8'h8C
`define TC_OFS_COUNT_ZERO 8'h90
`define TC_OFS_COUNT_ONE 8'h94

// ********************************************************
// Control register fields
// ********************************************************
`define TC_CTL_OVF_ONE 7
`define TC_CTL_RUN_ONE 6
`define TC_CTL_OVF_ZERO 5
`define TC_CTL_RUN_ZERO 4
`define TC_CTL_EXT_ONE 3
`define TC_CTL_TRIG_ONE 2
`define TC_CTL_EXT_ZERO 1
`define TC_CTL_TRIG_ZERO 0

// ********************************************************
// Mode register fields
// ********************************************************
`define TC_MOD_GATE_ONE 7
`define TC_MOD_CSEL_ONE 6
`define TC_MOD_MODE_ONE_HI 5
`define TC_MOD_MODE_ONE_LO 4
`define TC_MOD_GATE_ZERO 3
`define TC_MOD_CSEL_ZERO 2
`define TC_MOD_MODE_ZERO_HI 1
`define TC_MOD_MODE_ZERO_LO 0

// ********************************************************
// Reset values and bus answers
// ********************************************************
`define TC_RST_CONTROL 8'h00
`define TC_RST_MODE 8'h00
`define TC_RST_BYTE 8'h00
`define TC_BYTE_ALL_ONES 8'hFF
`define TC_RESP_OKAY 2'b00
`define TC_RESP_SLVERR 2'b10

`endif

// >>> shared/tc_pkg.sv
// Types shared by the timer pair and its helpers.
// Assumes the field layout of tc_map.svh.
package tc_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    MODE_PRESCALE,
    MODE_CASCADE,
    MODE_RELOAD,
    MODE_SPLIT
  } timer_mode_t;
endpackage

// >>> core/ext_request_unit.sv
// One external request flag with edge or low-level detection.
// Assumes the pin is synchronous to the system clock.
`timescale 1ns/1ps
module ext_request_unit (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Pin and configuration
  input wire logic i_pin,
  input wire logic i_trig_edge,
  // Vector acknowledge and software write
  input wire logic i_vec_ack,
  input wire logic i_sw_we,
  input wire logic i_sw_val,
  // Flag
  output logic o_flag
);
  logic pin_prev;
  logic fall;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= i_pin;
    end
  end

  assign fall = pin_prev & ~i_pin;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flag <= 1'b0;
    end else if (!i_trig_edge) begin
      o_flag <= ~i_pin; // [R15] [R17] [R19]
    end else if (fall) begin
      o_flag <= 1'b1; // [R16] [R18]
    end else if (i_sw_we) begin
      o_flag <= i_sw_val;
    end else if (i_vec_ack) begin
      o_flag <= 1'b0; // [R19]
    end
  end
endmodule

// >>> core/count_source.sv
// Count enable of one timer: gating, run bit and timer/counter source.
// Assumes the pins are synchronous to the system clock.
`timescale 1ns/1ps
module count_source (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Pins
  input wire logic i_count_pin,
  input wire logic i_gate_pin,
  // Configuration
  input wire logic i_run,
  input wire logic i_gate_en,
  input wire logic i_counter_sel,
  // Count enable
  output logic o_tick
);
  logic count_prev;
  logic count_evt;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_prev <= 1'b0;
    end else begin
      count_prev <= i_count_pin;
    end
  end

  // High in one sample, low in the next
  assign count_evt = count_prev & ~i_count_pin; // [R21]
  assign o_tick = i_run & (~i_gate_en | i_gate_pin)
                  & (i_counter_sel ? count_evt : 1'b1); // [R1] [R2] [R3] [R4] [R20]
endmodule

// >>> sim/pin_source.sv
// Pin model: count inputs and request pins of the timer pair.
// Assumes the bench calls its tasks from a process woken by i_clk_sys.
`timescale 1ns/1ps
module pin_source (
  // Clock
  input wire logic i_clk_sys,
  // Pins
  output logic o_count_pin_zero,
  output logic o_count_pin_one,
  output logic o_ext_request_pin_zero,
  output logic o_ext_request_pin_one
);
  logic [1:0] cnt = 2'b00;
  logic [1:0] req_lvl = 2'b11;
  assign o_count_pin_zero = cnt[0];
  assign o_count_pin_one = cnt[1];
  assign o_ext_request_pin_zero = req_lvl[0];
  assign o_ext_request_pin_one = req_lvl[1];
  // *****
  // Tasks
  // *****
  // Each level stands one full cycle
  task automatic pulse(input bit one, input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      cnt[one] <= 1'b1;
      @(posedge i_clk_sys);
      cnt[one] <= 1'b0;
    end
    repeat (2) @(posedge i_clk_sys);
  endtask
  // The level holds until the bench calls the task again
  task automatic req(input bit one, input logic lvl);
    @(posedge i_clk_sys);
    req_lvl[one] <= lvl;
  endtask
endmodule

// >>> sim/test_dual_timer_counter_control.sv
// Bench of the timer pair: AXI4-Lite register tasks and pin stimulus.
// Assumes pin_source on the pins and acknowledge pulses from the bench.
`timescale 1ns/1ps
`include "tc_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module test_dual_timer_counter_control;
  typedef struct {logic one; logic [7:0] mode; logic gp; logic [15:0] cnt; int n;
    logic [15:0] exp; logic ovf;} case_t;
  // *****
  // Signals
  // *****
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0, ack = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, cp0, cp1, rp0, rp1;
  logic f_ov0, f_ov1, f_ex0, f_ex1;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd_d;
  logic [15:0] exp16;
  int n_mismatch = 0, checks_done = 0, cyc = 0, b_cyc, t_start, diff;
  case_t c;
  case_t cases [9] = '{
    '{1'b0, 8'h05, 1'b1, 16'hFFFE, 3, 16'h0001, 1'b1},
    '{1'b0, 8'h04, 1'b1, 16'h00FE, 3, 16'h01E1, 1'b0},
    '{1'b0, 8'h06, 1'b1, 16'h40FE, 3, 16'h4041, 1'b1},
    '{1'b0, 8'h07, 1'b1, 16'h00FE, 3, 16'h0001, 1'b1},
    '{1'b0, 8'h0D, 1'b0, 16'h0000, 3, 16'h0000, 1'b0},
    '{1'b0, 8'h0D, 1'b1, 16'h0000, 3, 16'h0003, 1'b0},
    '{1'b1, 8'h50, 1'b1, 16'hFFFF, 1, 16'h0000, 1'b1},
    '{1'b1, 8'h70, 1'b1, 16'h1234, 2, 16'h1234, 1'b0},
    '{1'b1, 8'hD0, 1'b0, 16'h0000, 2, 16'h0000, 1'b0}};
  always #2 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) cyc <= cyc + 1;
  dual_timer_counter_control dut_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_count_pin_zero(cp0), .i_count_pin_one(cp1),
    .i_ext_request_pin_zero(rp0), .i_ext_request_pin_one(rp1),
    .i_vec_ack_overflow_zero(ack[0]), .i_vec_ack_overflow_one(ack[1]),
    .i_vec_ack_ext_zero(ack[2]), .i_vec_ack_ext_one(ack[3]),
    .o_overflow_flag_zero(f_ov0), .o_overflow_flag_one(f_ov1),
    .o_ext_request_flag_zero(f_ex0), .o_ext_request_flag_one(f_ex1));
  pin_source pins_u (.i_clk_sys(i_clk_sys), .o_count_pin_zero(cp0), .o_count_pin_one(cp1),
    .o_ext_request_pin_zero(rp0), .o_ext_request_pin_one(rp1));
  // *****
  // Tasks
  // *****
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bit aw, w;
    @(posedge i_clk_sys);
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge i_clk_sys);
      if (aw && awready) begin
        awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wready) begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
      if (bvalid) begin
        resp = bresp;
        b_cyc = cyc;
        bready <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    summarize();
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge i_clk_sys);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid) begin
        rd_d = rdata;
        resp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    summarize();
  endtask
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rd(`TC_OFS_CONTROL);
    `CHK(rd_d, 32'h0000_0000)
    rd(`TC_OFS_MODE);
    `CHK(rd_d, 32'h0000_0000)
    rd(8'h80);
    `CHK({resp, rd_d}, {`TC_RESP_SLVERR, 32'h0000_0000})
    wr(8'h80, 32'h0000_00FF, 4'b0001);
    `CHK(resp, `TC_RESP_SLVERR)
    $display("test reset and map done");
    for (int i = 0; i < 9; i++) begin
      c = cases[i];
      pins_u.req(c.one, c.gp);
      wr(`TC_OFS_MODE, {24'h00_0000, c.mode}, 4'b0001);
      wr(c.one ? `TC_OFS_COUNT_ONE : `TC_OFS_COUNT_ZERO, {16'h0000, c.cnt}, 4'b0011);
      wr(`TC_OFS_CONTROL, c.one ? 32'h0000_0040 : 32'h0000_0010, 4'b0001);
      pins_u.pulse(c.one, c.n);
      `CHK(c.one ? f_ov1 : f_ov0, c.ovf)
      rd(c.one ? `TC_OFS_COUNT_ONE : `TC_OFS_COUNT_ZERO);
      `CHK(rd_d[15:0], c.exp)
      ack[c.one] <= 1'b1;
      @(posedge i_clk_sys);
      ack <= 4'h0;
      repeat (2) @(posedge i_clk_sys);
      `CHK(c.one ? f_ov1 : f_ov0, 1'b0)
      wr(`TC_OFS_CONTROL, 32'h0000_0000, 4'b0001);
      pins_u.req(c.one, 1'b1);
    end
    $display("test modes done");
    for (int i = 0; i < 2; i++) begin
      wr(`TC_OFS_MODE, i ? 32'h0000_0003 : 32'h0000_0001, 4'b0001);
      wr(`TC_OFS_COUNT_ZERO, 32'h0000_0000, 4'b0011);
      wr(`TC_OFS_CONTROL, i ? 32'h0000_0040 : 32'h0000_0010, 4'b0001);
      t_start = b_cyc;
      wr(`TC_OFS_CONTROL, 32'h0000_0000, 4'b0001);
      diff = b_cyc - t_start;
      exp16 = i ? {diff[7:0], 8'h00} : diff[15:0];
      rd(`TC_OFS_COUNT_ZERO);
      `CHK(rd_d[15:0], exp16)
      repeat (5) @(posedge i_clk_sys);
      rd(`TC_OFS_COUNT_ZERO);
      `CHK(rd_d[15:0], exp16)
    end
    $display("test timer function done");
    for (int j = 0; j < 2; j++) begin
      wr(`TC_OFS_CONTROL, j ? 32'h0000_0004 : 32'h0000_0001, 4'b0001);
      pins_u.req(j, 1'b0);
      repeat (3) @(posedge i_clk_sys);
      `CHK(j ? f_ex1 : f_ex0, 1'b1)
      pins_u.req(j, 1'b1);
      repeat (3) @(posedge i_clk_sys);
      `CHK(j ? f_ex1 : f_ex0, 1'b1)
      ack[2 + j] <= 1'b1;
      @(posedge i_clk_sys);
      ack <= 4'h0;
      repeat (2) @(posedge i_clk_sys);
      `CHK(j ? f_ex1 : f_ex0, 1'b0)
      wr(`TC_OFS_CONTROL, 32'h0000_0000, 4'b0001);
      pins_u.req(j, 1'b0);
      repeat (3) @(posedge i_clk_sys);
      rd(`TC_OFS_CONTROL);
      `CHK(rd_d[j ? 3 : 1], 1'b1)
      pins_u.req(j, 1'b1);
      repeat (3) @(posedge i_clk_sys);
      `CHK(j ? f_ex1 : f_ex0, 1'b0)
    end
    $display("test request flags done");
    summarize();
  end
endmodule
